// ===== rtl/chan_cond_map.svh
// constants for the eight-channel voltage input conditioning pair
// assumes the 125 MHz module clock; included by both ends
`ifndef CHAN_COND_MAP_SVH
`define CHAN_COND_MAP_SVH

// ==========================================
// timing
`define CLK_NS 8
`define SCAN_60HZ_NS 1040000
`define SCAN_50HZ_NS 1250000
`define COMM_TIMEOUT_NS 3750000

// ==========================================
// engineering limits
`define EU_LIMIT 16'sh7fff
`define SPAN_LIMIT 16'sh2710
`define DEF_SPAN_LO 16'hd8f0
`define DEF_HIGH_SPAN_POINT 16'h2710
`define DEF_EU_LO 16'hd8f0
`define DEF_EU_HI 16'h2710
`define DEF_ALM_LO 16'hd8f0
`define DEF_ALM_HI 16'h2710

// ==========================================
// register byte offsets (bits 7:5 select the region, 4:2 the channel)
`define REG_CTRL 8'h00
`define REG_RANGE 8'h04
`define REG_STATUS 8'h08
`define REG_DATA 3'h1
`define REG_SPAN 3'h2
`define REG_EU 3'h3
`define REG_ALARM 3'h4

// ==========================================
// field positions and reset values
`define CTRL_ACTIVE_LSB 0
`define CTRL_FILTER_LSB 8
`define CTRL_LINE50_BIT 10
`define CTRL_HOLD_BIT 11
`define RANGE_UNI_LSB 0
`define RANGE_CUSTOM_LSB 8
`define STAT_ALM_LO_LSB 0
`define STAT_ALM_HI_LSB 8
`define STAT_LOST_BIT 16
`define RST_ACTIVE 8'hff

`endif

// ===== rtl/chan_cond_pkg.sv
// types shared by the conditioning module and the station interface unit
// assumes chan_cond_map.svh for the numeric constants
package chan_cond_pkg;

  typedef enum logic [1:0] {FILT_NONE, FILT_8, FILT_16} filter_mode_t;

  typedef enum logic {ST_WAIT, ST_SCAN} scan_state_t;

  typedef struct packed {
    scan_state_t st;
    logic [17:0] timer;
    logic [2:0] ch;
    logic [3:0] wp;
    logic [7:0][15:0][15:0] hist;
    logic [7:0][20:0] sum8;
    logic [7:0][20:0] sum16;
    logic word_valid;
    logic [2:0] word_ch;
    logic [15:0] word_data;
    logic word_alm_lo;
    logic word_alm_hi;
    logic [7:0] alarm_lo;
    logic [7:0] alarm_hi;
    logic [7:0] fault;
  } dev_state_t;

  typedef struct packed {
    logic [7:0] active;
    filter_mode_t filter;
    logic line_50;
    logic hold;
    logic [7:0] uni;
    logic [7:0] custom;
    logic [7:0][15:0] span_lo;
    logic [7:0][15:0] high_span_point;
    logic [7:0][15:0] eu_lo;
    logic [7:0][15:0] eu_hi;
    logic [7:0][15:0] alm_lo;
    logic [7:0][15:0] alm_hi;
    logic [7:0][15:0] data;
    logic [7:0] st_lo;
    logic [7:0] st_hi;
    logic [19:0] wd;
    logic lost;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic hreadyout;
  } unit_state_t;

endpackage

// ===== rtl/chan_link_if.sv
// link between the conditioning module and the station interface unit
// both ends share hclk; the bench joins the two modports
`timescale 1ns/1ps
interface chan_link_if;
  logic [7:0] chan_active;
  chan_cond_pkg::filter_mode_t filter_mode;
  logic line_50;
  logic [7:0] range_uni;
  logic [7:0] custom_en;
  logic [7:0][15:0] span_lo;
  logic [7:0][15:0] high_span_point;
  logic [7:0][15:0] eu_lo;
  logic [7:0][15:0] eu_hi;
  logic [7:0][15:0] alm_lo;
  logic [7:0][15:0] alm_hi;
  logic word_valid;
  logic [2:0] word_ch;
  logic [15:0] word_data;
  logic word_alm_lo;
  logic word_alm_hi;

  modport device (
    input chan_active, filter_mode, line_50, range_uni, custom_en,
    input span_lo, high_span_point, eu_lo, eu_hi, alm_lo, alm_hi,
    output word_valid, word_ch, word_data, word_alm_lo, word_alm_hi
  );
  modport unit (
    output chan_active, filter_mode, line_50, range_uni, custom_en,
    output span_lo, high_span_point, eu_lo, eu_hi, alm_lo, alm_hi,
    input word_valid, word_ch, word_data, word_alm_lo, word_alm_hi
  );
endinterface // chan_link_if

// ===== rtl/station_interface_unit.sv
// station interface unit: ahb-lite register slave that configures the
// conditioning module over the link and collects its scaled words
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "chan_cond_map.svh"
module station_interface_unit #(
  parameter int COMM_TIMEOUT_CYC = `COMM_TIMEOUT_NS / `CLK_NS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic comm_lost,
  chan_link_if.unit lnk
);

  chan_cond_pkg::unit_state_t s_ff;
  chan_cond_pkg::unit_state_t nxt_s;
  logic hresp_ff;

  // clamp a signed word to +-lim
  function automatic logic [15:0] sat16(input logic signed [15:0] v, input logic signed [15:0] lim);
    if (v > lim) begin
      return lim;
    end else if (v < -lim) begin
      return 16'(-lim);
    end
    return v;
  endfunction

  // ==========================================
  // next state
  always_comb begin
    logic [2:0] wch;
    logic [2:0] rch;
    logic [15:0] wl;
    logic [15:0] wh;
    wch = s_ff.ap_addr[4:2];
    rch = haddr[4:2];
    wl = 16'h0000;
    wh = 16'h0000;
    nxt_s = s_ff;
    if (clk_en) begin
      // data phase write: first, so a following read sees it
      if (s_ff.ap_valid && s_ff.ap_write) begin
        case (s_ff.ap_addr[7:5])
          3'h0: begin
            if (s_ff.ap_addr == `REG_CTRL) begin
              nxt_s.active = hwdata[`CTRL_ACTIVE_LSB +: 8];
              nxt_s.filter = chan_cond_pkg::filter_mode_t'(hwdata[`CTRL_FILTER_LSB +: 2]);
              nxt_s.line_50 = hwdata[`CTRL_LINE50_BIT];
              nxt_s.hold = hwdata[`CTRL_HOLD_BIT];
            end else if (s_ff.ap_addr == `REG_RANGE) begin
              nxt_s.uni = hwdata[`RANGE_UNI_LSB +: 8];
              nxt_s.custom = hwdata[`RANGE_CUSTOM_LSB +: 8];
            end
          end
          `REG_SPAN: begin
            nxt_s.span_lo[wch] = sat16(hwdata[15:0], `SPAN_LIMIT);
            nxt_s.high_span_point[wch] = sat16(hwdata[31:16], `SPAN_LIMIT);
          end
          `REG_EU: begin
            nxt_s.eu_lo[wch] = sat16(hwdata[15:0], `EU_LIMIT);
            nxt_s.eu_hi[wch] = sat16(hwdata[31:16], `EU_LIMIT);
          end
          `REG_ALARM: begin
            wl = sat16(hwdata[15:0], `EU_LIMIT);
            wh = sat16(hwdata[31:16], `EU_LIMIT);
            // a pair with high not above low is dropped whole
            if ($signed(wh) > $signed(wl)) begin
              nxt_s.alm_lo[wch] = wl;
              nxt_s.alm_hi[wch] = wh;
            end
          end
          default: begin
          end
        endcase
      end
      // link words and loss watchdog
      if (lnk.word_valid) begin
        nxt_s.data[lnk.word_ch] = lnk.word_data;
        nxt_s.st_lo[lnk.word_ch] = lnk.word_alm_lo;
        nxt_s.st_hi[lnk.word_ch] = lnk.word_alm_hi;
        nxt_s.wd = 20'h00000;
        nxt_s.lost = 1'b0;
      end else if (s_ff.wd == 20'(COMM_TIMEOUT_CYC)) begin
        nxt_s.lost = 1'b1;
        if (!s_ff.hold) begin
          nxt_s.data = '0;
          nxt_s.st_lo = 8'h00;
          nxt_s.st_hi = 8'h00;
        end
      end else begin
        nxt_s.wd = s_ff.wd + 20'h00001;
      end
      // address phase
      nxt_s.ap_valid = hsel && hready && htrans[1];
      nxt_s.ap_write = hwrite;
      nxt_s.ap_addr = haddr[7:0];
      nxt_s.hrdata = 32'h00000000;
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[7:5])
          3'h0: begin
            if (haddr[7:0] == `REG_CTRL) begin
              nxt_s.hrdata[`CTRL_ACTIVE_LSB +: 8] = nxt_s.active;
              nxt_s.hrdata[`CTRL_FILTER_LSB +: 2] = nxt_s.filter;
              nxt_s.hrdata[`CTRL_LINE50_BIT] = nxt_s.line_50;
              nxt_s.hrdata[`CTRL_HOLD_BIT] = nxt_s.hold;
            end else if (haddr[7:0] == `REG_RANGE) begin
              nxt_s.hrdata[`RANGE_UNI_LSB +: 8] = nxt_s.uni;
              nxt_s.hrdata[`RANGE_CUSTOM_LSB +: 8] = nxt_s.custom;
            end else if (haddr[7:0] == `REG_STATUS) begin
              nxt_s.hrdata[`STAT_ALM_LO_LSB +: 8] = nxt_s.st_lo;
              nxt_s.hrdata[`STAT_ALM_HI_LSB +: 8] = nxt_s.st_hi;
              nxt_s.hrdata[`STAT_LOST_BIT] = nxt_s.lost;
            end
          end
          `REG_DATA: nxt_s.hrdata = {{16{nxt_s.data[rch][15]}}, nxt_s.data[rch]};
          `REG_SPAN: nxt_s.hrdata = {nxt_s.high_span_point[rch], nxt_s.span_lo[rch]};
          `REG_EU: nxt_s.hrdata = {nxt_s.eu_hi[rch], nxt_s.eu_lo[rch]};
          `REG_ALARM: nxt_s.hrdata = {nxt_s.alm_hi[rch], nxt_s.alm_lo[rch]};
          default: nxt_s.hrdata = 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
      s_ff.active <= `RST_ACTIVE;
      s_ff.span_lo <= {8{`DEF_SPAN_LO}};
      s_ff.high_span_point <= {8{`DEF_HIGH_SPAN_POINT}};
      s_ff.eu_lo <= {8{`DEF_EU_LO}};
      s_ff.eu_hi <= {8{`DEF_EU_HI}};
      s_ff.alm_lo <= {8{`DEF_ALM_LO}};
      s_ff.alm_hi <= {8{`DEF_ALM_HI}};
      s_ff.hreadyout <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      s_ff <= nxt_s;
      hresp_ff <= 1'b0;
    end
  end

  assign hrdata = s_ff.hrdata;
  assign hreadyout = s_ff.hreadyout;
  assign hresp = hresp_ff;
  assign comm_lost = s_ff.lost;
  assign lnk.chan_active = s_ff.active;
  assign lnk.filter_mode = s_ff.filter;
  assign lnk.line_50 = s_ff.line_50;
  assign lnk.range_uni = s_ff.uni;
  assign lnk.custom_en = s_ff.custom;
  assign lnk.span_lo = s_ff.span_lo;
  assign lnk.high_span_point = s_ff.high_span_point;
  assign lnk.eu_lo = s_ff.eu_lo;
  assign lnk.eu_hi = s_ff.eu_hi;
  assign lnk.alm_lo = s_ff.alm_lo;
  assign lnk.alm_hi = s_ff.alm_hi;

endmodule // station_interface_unit

// ===== rtl/voltage_input_channel_conditioning.sv
// eight-channel voltage input conditioning: scan timing, averaging,
// range or two-point scaling, clamping and alarm compare
// assumes adc_mv holds each channel's latest millivolt conversion,
// synchronous to hclk, and that configuration arrives over chan_link_if
`timescale 1ns/1ps
`include "chan_cond_map.svh"

module voltage_input_channel_conditioning #(
  parameter int SCAN_60HZ_CYC = `SCAN_60HZ_NS / `CLK_NS,
  parameter int SCAN_50HZ_CYC = `SCAN_50HZ_NS / `CLK_NS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic [7:0][15:0] adc_mv,
  output logic [7:0] alarm_lo,
  output logic [7:0] alarm_hi,
  output logic [7:0] chan_fault,
  chan_link_if.device lnk
);

  chan_cond_pkg::dev_state_t s_ff;
  chan_cond_pkg::dev_state_t nxt_s;

  // ==========================================
  // millivolt to engineering units
  function automatic logic [15:0] scale_mv(
    input logic signed [15:0] mv,
    input logic uni,
    input logic custom,
    input logic signed [15:0] sl,
    input logic signed [15:0] sh,
    input logic signed [15:0] el,
    input logic signed [15:0] eh
  );
    logic signed [16:0] d_mv;
    logic signed [16:0] d_eu;
    logic signed [16:0] den;
    logic signed [33:0] num;
    logic signed [33:0] r;
    d_mv = 17'(mv) - 17'(sl);
    d_eu = 17'(eh) - 17'(el);
    den = 17'(sh) - 17'(sl);
    num = d_mv * d_eu;
    r = 34'(mv);
    if (custom) begin
      // a zero span would divide by zero: pin to the low point
      if (den == 17'sh00000) begin
        r = 34'(el);
      end else begin
        r = 34'(el) + num / 34'(den);
      end
    end else if (uni && mv < 16'sh0000) begin
      r = 34'sh000000000;
    end
    if (r < -34'(`EU_LIMIT)) begin
      r = -34'(`EU_LIMIT);
    end else if (r > 34'(`EU_LIMIT)) begin
      r = 34'(`EU_LIMIT);
    end
    return r[15:0];
  endfunction

  // ==========================================
  // window select; one shared history feeds separate 8- and 16-sample running sums
  function automatic logic [15:0] pick_avg(
    input chan_cond_pkg::filter_mode_t mode,
    input logic signed [15:0] smp,
    input logic signed [20:0] s8,
    input logic signed [20:0] s16
  );
    logic [15:0] v;
    v = smp;
    // arithmetic shift: means round toward minus infinity
    case (mode)
      chan_cond_pkg::FILT_8: v = 16'(s8 >>> 3);
      chan_cond_pkg::FILT_16: v = 16'(s16 >>> 4);
      default: v = smp;
    endcase
    return v;
  endfunction

  // ==========================================
  // error check: conversion beyond the bipolar input span
  function automatic logic out_of_span(input logic signed [15:0] mv);
    return (mv > `SPAN_LIMIT) || (mv < -`SPAN_LIMIT);
  endfunction

  // ==========================================
  // next state
  always_comb begin
    logic [2:0] c;
    logic [3:0] wp8;
    logic signed [15:0] smp;
    logic signed [20:0] s8;
    logic signed [20:0] s16;
    logic signed [15:0] filt;
    logic signed [15:0] eu;
    c = s_ff.ch;
    wp8 = s_ff.wp + 4'h8;
    smp = adc_mv[c];
    s8 = 21'sh000000;
    s16 = 21'sh000000;
    filt = 16'sh0000;
    eu = 16'sh0000;
    nxt_s = s_ff;
    // the word strobe freezes with the rest, so a stalled pulse is not lost
    if (clk_en) begin
      nxt_s.word_valid = 1'b0;
      // free-running period timer, reloaded per line frequency
      if (s_ff.timer == 18'h00000) begin
        nxt_s.timer = lnk.line_50 ? 18'(SCAN_50HZ_CYC - 1) : 18'(SCAN_60HZ_CYC - 1);
        nxt_s.st = chan_cond_pkg::ST_SCAN;
        nxt_s.ch = 3'h0;
      end else begin
        nxt_s.timer = s_ff.timer - 18'h00001;
      end
      // ==========================================
      // one channel per cycle while scanning
      case (s_ff.st)
        chan_cond_pkg::ST_WAIT: begin
        end
        chan_cond_pkg::ST_SCAN: begin
          if (lnk.chan_active[c]) begin
            // running sums: add the new sample, drop the one leaving each window
            s8 = $signed(s_ff.sum8[c]) + 21'(smp) - 21'($signed(s_ff.hist[c][wp8]));
            s16 = $signed(s_ff.sum16[c]) + 21'(smp) - 21'($signed(s_ff.hist[c][s_ff.wp]));
            nxt_s.hist[c][s_ff.wp] = smp;
            nxt_s.sum8[c] = s8;
            nxt_s.sum16[c] = s16;
            filt = pick_avg(lnk.filter_mode, smp, s8, s16);
            eu = scale_mv(
              filt,
              lnk.range_uni[c],
              lnk.custom_en[c],
              lnk.span_lo[c],
              lnk.high_span_point[c],
              lnk.eu_lo[c],
              lnk.eu_hi[c]
            );
            nxt_s.alarm_lo[c] = eu < $signed(lnk.alm_lo[c]);
            nxt_s.alarm_hi[c] = eu > $signed(lnk.alm_hi[c]);
            nxt_s.fault[c] = out_of_span(smp);
          end else begin
            eu = 16'sh0000;
            nxt_s.alarm_lo[c] = 1'b0;
            nxt_s.alarm_hi[c] = 1'b0;
            nxt_s.fault[c] = 1'b0;
          end
          nxt_s.word_valid = 1'b1;
          nxt_s.word_ch = c;
          nxt_s.word_data = eu;
          nxt_s.word_alm_lo = nxt_s.alarm_lo[c];
          nxt_s.word_alm_hi = nxt_s.alarm_hi[c];
          nxt_s.ch = c + 3'h1;
          if (c == 3'h7) begin
            nxt_s.st = chan_cond_pkg::ST_WAIT;
            nxt_s.wp = s_ff.wp + 4'h1;
          end
        end
        default: nxt_s.st = chan_cond_pkg::ST_WAIT;
      endcase
    end
  end

  // ==========================================
  // state register; range and scaling defaults live in the unit's reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================
  // outputs straight from the state flops
  assign alarm_lo = s_ff.alarm_lo;
  assign alarm_hi = s_ff.alarm_hi;
  assign chan_fault = s_ff.fault;
  assign lnk.word_valid = s_ff.word_valid;
  assign lnk.word_ch = s_ff.word_ch;
  assign lnk.word_data = s_ff.word_data;
  assign lnk.word_alm_lo = s_ff.word_alm_lo;
  assign lnk.word_alm_hi = s_ff.word_alm_hi;

endmodule // voltage_input_channel_conditioning

// ===== tb/chan_link_assertions.sv
// concurrent checks on the link between conditioning module and interface unit
// assumes the bench instantiates it beside chan_link_if, reset by the device reset
`timescale 1ns/1ps
module chan_link_assertions #(
  parameter int SCAN_60HZ_CYC = 40,
  parameter int SCAN_50HZ_CYC = 50
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic [7:0] chan_active,
  input wire logic line_50,
  input wire logic [7:0] range_uni,
  input wire logic [7:0] custom_en,
  input wire logic [7:0][15:0] alm_lo,
  input wire logic [7:0][15:0] alm_hi,
  input wire logic word_valid,
  input wire logic [2:0] word_ch,
  input wire logic [15:0] word_data,
  input wire logic word_alm_lo,
  input wire logic word_alm_hi
);
  // ======
  // scan gap counter
  logic [31:0] gap_ff;
  logic seen_ff;
  logic line_ff;
  logic ch0;
  assign ch0 = word_valid && word_ch == 3'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_ff <= 32'h0;
      seen_ff <= 1'b0;
      line_ff <= 1'b0;
    end else begin
      // frozen cycles do not count toward the period
      gap_ff <= ch0 ? 32'h0 : gap_ff + {31'h0, clk_en};
      seen_ff <= seen_ff | ch0;
      line_ff <= ch0 ? line_50 : line_ff;
    end
  end
  // ======
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // skipped across a line change: which period applies then is open
  property p_period;
    ch0 && seen_ff && line_50 == line_ff |-> gap_ff + 32'h1 == (line_50 ? SCAN_50HZ_CYC : SCAN_60HZ_CYC);
  endproperty
  a_period: assert property (p_period) else $error("scan period wrong");
  property p_next_ch;
    word_valid && word_ch != 3'h7 |=> word_valid && word_ch == $past(word_ch) + 3'h1;
  endproperty
  a_next_ch: assert property (p_next_ch) else $error("channel order broken");
  property p_burst_end;
    word_valid && word_ch == 3'h7 |=> !word_valid;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst too long");
  property p_inactive;
    word_valid && !chan_active[word_ch] |-> word_data == 16'h0 && !word_alm_lo && !word_alm_hi;
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive word not zero");
  property p_clamp_min;
    word_valid |-> word_data != 16'h8000;
  endproperty
  a_clamp_min: assert property (p_clamp_min) else $error("minimum below limit");
  property p_uni_pos;
    word_valid && range_uni[word_ch] && !custom_en[word_ch] |-> !word_data[15];
  endproperty
  a_uni_pos: assert property (p_uni_pos) else $error("unipolar word negative");
  property p_alm_lo;
    word_valid |-> word_alm_lo == (chan_active[word_ch] && $signed(word_data) < $signed(alm_lo[word_ch]));
  endproperty
  a_alm_lo: assert property (p_alm_lo) else $error("low alarm flag wrong");
  property p_alm_hi;
    word_valid |-> word_alm_hi == (chan_active[word_ch] && $signed(word_data) > $signed(alm_hi[word_ch]));
  endproperty
  a_alm_hi: assert property (p_alm_hi) else $error("high alarm flag wrong");
  property p_alm_excl;
    word_valid |-> !(word_alm_lo && word_alm_hi);
  endproperty
  a_alm_excl: assert property (p_alm_excl) else $error("both alarms set");
endmodule // chan_link_assertions

// ===== tb/voltage_input_channel_conditioning_tb.sv
// self-checking bench for the conditioning module and interface unit pair
// assumes one shared hclk; software side driven as a single ahb-lite master
`timescale 1ns/1ps
module voltage_input_channel_conditioning_tb;
  // ======
  // signals
  typedef struct packed {
    logic uni;
    logic cust;
    logic [15:0] mv;
    logic [15:0] eu;
  } row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic dev_alive = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0][15:0] adc_mv = '0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, comm_lost, dev_rstn;
  logic [7:0] alarm_lo, alarm_hi, chan_fault;
  int err_count = 0;
  int n_tests = 0;
  row_t rows [8];
  // device reset also cut alone, to make the unit lose its link
  assign dev_rstn = hresetn & dev_alive;
  always #4 hclk = ~hclk;
  chan_link_if lnk ();
  voltage_input_channel_conditioning #(.SCAN_60HZ_CYC(40), .SCAN_50HZ_CYC(50)) i_voltage_input_channel_conditioning (
    .hclk(hclk), .hresetn(dev_rstn), .clk_en(clk_en), .adc_mv(adc_mv), .alarm_lo(alarm_lo),
    .alarm_hi(alarm_hi), .chan_fault(chan_fault), .lnk(lnk));
  station_interface_unit #(.COMM_TIMEOUT_CYC(200)) i_station_interface_unit (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .comm_lost(comm_lost), .lnk(lnk));
  chan_link_assertions #(.SCAN_60HZ_CYC(40), .SCAN_50HZ_CYC(50)) i_chan_link_assertions (
    .hclk(hclk), .hresetn(dev_rstn), .clk_en(clk_en), .chan_active(lnk.chan_active), .line_50(lnk.line_50),
    .range_uni(lnk.range_uni), .custom_en(lnk.custom_en), .alm_lo(lnk.alm_lo), .alm_hi(lnk.alm_hi),
    .word_valid(lnk.word_valid), .word_ch(lnk.word_ch), .word_data(lnk.word_data),
    .word_alm_lo(lnk.word_alm_lo), .word_alm_hi(lnk.word_alm_hi));
  // ======
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      final_report();
    end
  endtask
  // one word, address phase held until hready, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // waits out n bursts; k counts edges to the end of the last one, for period checks
  task automatic burst(input int n, output int k);
    repeat (n) begin
      k = 0;
      do begin
        @(posedge hclk);
        k++;
      end while (!(lnk.word_valid === 1'b1 && lnk.word_ch === 3'h7) && k < 300);
      if (k >= 300) begin
        err_count++;
        final_report();
      end
    end
  endtask
  // ======
  // sequence
  initial begin
    logic lo0, hi0, lo_o, hi_o;
    int k;
    rows = '{'{1'b0, 1'b0, 16'h2710, 16'h2710}, '{1'b0, 1'b0, 16'hd8f0, 16'hd8f0},
      '{1'b1, 1'b0, 16'hec78, 16'h0000}, '{1'b1, 1'b0, 16'h1b58, 16'h1b58},
      '{1'b0, 1'b1, 16'h01f4, 16'h2710}, '{1'b0, 1'b1, 16'h07d0, 16'h7fff},
      '{1'b0, 1'b1, 16'hf830, 16'h8001}, '{1'b0, 1'b0, 16'h2ee0, 16'h2ee0}};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // custom points on channel 0: 0..1000 mV to 0..20000 units
    wr(8'h40, 32'h03e80000);
    wr(8'h60, 32'h4e200000);
    foreach (rows[i]) begin
      wr(8'h04, {23'h0, rows[i].cust, 7'h0, rows[i].uni});
      adc_mv <= {8{rows[i].mv}};
      burst(2, k);
      lo0 = $signed(rows[i].eu) < -16'sd10000;
      hi0 = $signed(rows[i].eu) > 16'sd10000;
      lo_o = $signed(rows[i].mv) < -16'sd10000;
      hi_o = $signed(rows[i].mv) > 16'sd10000;
      rchk(8'h20, {{16{rows[i].eu[15]}}, rows[i].eu});
      rchk(8'h08, {16'h0, {7{hi_o}}, hi0, {7{lo_o}}, lo0});
      check(alarm_lo, {{7{lo_o}}, lo0});
      check(alarm_hi, {{7{hi_o}}, hi0});
      check(chan_fault, {8{lo_o | hi_o}});
      $display("test row %0d done", i);
    end
    wr(8'h04, 32'h0);
    // zero history first, then a step: partial means show the window slide
    for (int f = 1; f < 3; f++) begin
      wr(8'h00, 32'hff);
      adc_mv <= '0;
      burst(17, k);
      wr(8'h00, 32'hff | (f << 8));
      adc_mv <= {8{16'h0640}};
      burst(1, k);
      rchk(8'h20, 32'h640 >> (f + 2));
      rchk(8'h24, 32'h640 >> (f + 2));
      burst((8 << (f - 1)) - 1, k);
      rchk(8'h20, 32'h640);
      $display("test filter %0d done", f);
    end
    wr(8'h00, 32'hfe);
    adc_mv <= {8{16'h0bb8}};
    burst(2, k);
    rchk(8'h20, 32'h0);
    rchk(8'h24, 32'hbb8);
    $display("test inactive done");
    wr(8'h00, 32'hff);
    burst(2, k);
    check(k, 32'd40);
    wr(8'h00, 32'h4ff);
    burst(2, k);
    check(k, 32'd50);
    $display("test line rate done");
    for (int h = 0; h < 2; h++) begin
      wr(8'h00, 32'hff | (h << 11));
      burst(2, k);
      dev_alive <= 1'b0;
      repeat (210) @(posedge hclk);
      check(comm_lost, 32'h1);
      rchk(8'h20, (h == 1) ? 32'hbb8 : 32'h0);
      dev_alive <= 1'b1;
      burst(2, k);
      check(comm_lost, 32'h0);
      $display("test loss %0d done", h);
    end
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(8'h00, 32'hff);
    rchk(8'h04, 32'h0);
    rchk(8'h40, 32'h2710d8f0);
    rchk(8'h60, 32'h2710d8f0);
    rchk(8'h80, 32'h2710d8f0);
    rchk(8'hfc, 32'h0);
    burst(2, k);
    rchk(8'h20, 32'hbb8);
    $display("test reset done");
    // configurer limits: alarm pair with high not above low dropped, others saturate
    wr(8'h84, 32'h00000064);
    rchk(8'h84, 32'h2710d8f0);
    wr(8'h44, 32'h3a9803e8);
    rchk(8'h44, 32'h271003e8);
    wr(8'h64, 32'h80007fff);
    rchk(8'h64, 32'h80017fff);
    check(hresp, 32'h0);
    // enable low for three edges: write lost, scan timer stands still
    burst(1, k);
    clk_en <= 1'b0;
    wr(8'h00, 32'h000000fe);
    clk_en <= 1'b1;
    burst(1, k);
    check(k, 32'd40);
    rchk(8'h00, 32'hff);
    $display("test limits and enable done");
    final_report();
  end
endmodule // voltage_input_channel_conditioning_tb
